// [capture_timestamp_sync.sv]
// Capture time stamp block: 33-bit 90 kHz capture clock, per-frame stamp
// latch, user data record insertion, valid video flag, telecine dropping.
// Assumes strobes synchronous to clk_sys and a byte sink with ready.
//
// Functional notes
// - A 33-bit capture counter advances once per 90 kHz tick.
// - The counter clears to zero when the encode start command comes.
// - Each frame's stamp is the counter value at its first active pixel.
// - A user data record opening with 000001b2 follows each header that arrives while no record is in progress.
// - The two-byte identifier 0207 follows the start code.
// - Five stamp bytes: pad, bits 32-30, marker, 29-15, marker, 14-0.
// - A two-bit select picks decoder pixel clock or main clock as base.
// - The valid video flag is high only while valid video is sampled.
// - Capture halts on sync loss and resumes at the next valid sync.
// - Lost frames only move the stamp forward, never backward.
// - Telecine detection works only for NTSC and drops duplicates.
// - Film cadence swaps NTSC and 24 fps sequences, in both directions.
// - In a film sequence one of every five source frames is dropped.

`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------------------------------
// Shift FIFO, head word held in slot zero so it leaves from a flop
// --------------------------------------------------------------------
module byte_fifo
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] C_ZERO = '0;
   localparam logic [CW-1:0] C_ONE  = CW'(1);
   localparam logic [CW-1:0] C_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;
   logic [CW-1:0]    wr_slot;
   logic             push;
   logic             pop;

   // Handshakes; a pop frees a slot for the same cycle's push position
   assign push       = in_valid & in_ready;
   assign pop        = out_valid & out_ready;
   assign next_count = count + (push ? C_ONE : C_ZERO)
                       - (pop ? C_ONE : C_ZERO);
   assign wr_slot    = pop ? count - C_ONE : count;
   assign out_data   = mem[0];

   // Occupancy and flags, registered so ready and valid are honest
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || (clk_en && flush))
      begin
         count     <= C_ZERO;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end
      else if (clk_en)
      begin
         count     <= next_count;
         in_ready  <= (next_count != C_FULL);
         out_valid <= (next_count != C_ZERO);
      end
   end

   // Storage shifts toward slot zero on each pop
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_slot
      always_ff @(posedge clk_sys)
      begin
         if (!rst_b)
            mem[i] <= '0;
         else if (clk_en)
         begin
            if (push && wr_slot == CW'(i))
               mem[i] <= in_data;
            else if (pop && i < DEPTH - 1)
               mem[i] <= mem[(i + 1) % DEPTH];
         end
      end
   end
endmodule

// --------------------------------------------------------------------
// Top level
// --------------------------------------------------------------------
module capture_timestamp_sync
   import capture_timestamp_sync_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        start_cmd,
   input  wire logic [1:0]  time_base_select,
   input  wire logic        decoder_pixel_clock,
   input  wire logic        main_clock_input,
   input  wire frame_evt_s  frame_in,
   input  wire telecine_s   telecine_in,
   output logic             valid_video_flag,
   output logic             capturing,
   output logic             frame_drop,
   output logic             seq_end,
   output logic             seq_start,
   output logic             seq_film,
   output logic [TS_W-1:0]  stamp,
   output logic [7:0]       stream_data,
   output logic             stream_valid,
   input  wire logic        stream_ready
);
   typedef enum logic [0:0] {
      SEQ_NTSC = 1'b0,
      SEQ_FILM = 1'b1
   } seq_mode_e;

   typedef enum logic [0:0] {
      EM_IDLE = 1'b0,
      EM_SEND = 1'b1
   } emit_state_e;

   // -----------------------------------------------------------------
   // Time base
   // -----------------------------------------------------------------
   logic [DIV_W-1:0] div_count;
   logic [TS_W-1:0]  capture_count;
   logic             src_edge;
   logic             tick;

   // Source pick; reserved codes fall back to the main clock
   assign src_edge = (time_base_select == TB_DECODER)
                     ? decoder_pixel_clock
                     : main_clock_input;
   assign tick     = src_edge && (div_count == DIV_LAST);

   // Divide source cycles down to 90 kHz, counter wraps modulo 2^33
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         div_count     <= '0;
         capture_count <= TS_ZERO;
      end
      else if (clk_en)
      begin
         if (start_cmd)
         begin
            div_count     <= '0;
            capture_count <= TS_ZERO;
         end
         else if (src_edge)
         begin
            div_count <= tick ? '0 : div_count + 1'b1;
            if (tick)
               capture_count <= capture_count + TS_ONE;
         end
      end
   end

   // -----------------------------------------------------------------
   // Sync tracking and telecine
   // -----------------------------------------------------------------
   seq_mode_e seq_mode;
   logic [2:0] film_slot;
   logic       film_allowed;
   logic       drop_now;

   // Detection only counts on NTSC; elsewhere the cadence input is moot
   assign film_allowed = telecine_in.detect_enable
                         && telecine_in.ntsc;
   assign drop_now     = (seq_mode == SEQ_FILM)
                         && (film_slot == FILM_DROP_SLOT);

   // Capture gate: stop on lost sync, restart on next good vsync
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         capturing <= 1'b0;
      else if (clk_en)
      begin
         if (frame_in.vsync_lost)
            capturing <= 1'b0;
         else if (frame_in.vsync)
            capturing <= 1'b1;
      end
   end

   // Valid video flag follows sampled active video while capturing, cleared on sync loss or a dropped frame
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         valid_video_flag <= 1'b0;
      else if (clk_en)
         valid_video_flag <= capturing && frame_in.active
                             && !frame_in.vsync_lost
                             && !frame_drop;
   end

   // Sequence mode switches with end and start strobes on each change
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         seq_mode   <= SEQ_NTSC;
         film_slot  <= FILM_ZERO;
         frame_drop <= 1'b0;
         seq_end    <= 1'b0;
         seq_start  <= 1'b0;
      end
      else if (clk_en)
      begin
         seq_end   <= 1'b0;
         seq_start <= 1'b0;
         if (frame_in.vsync && capturing)
         begin
            unique case (seq_mode)
               SEQ_NTSC:
               begin
                  frame_drop <= 1'b0;
                  if (film_allowed && telecine_in.film_found)
                  begin
                     seq_mode  <= SEQ_FILM;
                     seq_end   <= 1'b1;
                     seq_start <= 1'b1;
                     film_slot <= FILM_ZERO;
                  end
               end
               SEQ_FILM:
               begin
                  if (!(film_allowed && telecine_in.film_found))
                  begin
                     seq_mode   <= SEQ_NTSC;
                     seq_end    <= 1'b1;
                     seq_start  <= 1'b1;
                     frame_drop <= 1'b0;
                  end
                  else
                  begin
                     frame_drop <= drop_now;
                     film_slot  <= drop_now ? FILM_ZERO
                                            : film_slot + FILM_ONE;
                  end
               end
            endcase
         end
      end
   end

   assign seq_film = (seq_mode == SEQ_FILM);

   // -----------------------------------------------------------------
   // Stamp latch
   // -----------------------------------------------------------------
   logic stamp_take;

   // Dropped or uncaptured frames leave the stamp alone, so gaps only
   // show as a forward jump on the next kept frame
   assign stamp_take = frame_in.first_pixel && capturing && !frame_drop;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         stamp <= TS_ZERO;
      else if (clk_en)
      begin
         if (start_cmd)
            stamp <= TS_ZERO;
         else if (stamp_take)
            stamp <= capture_count;
      end
   end

   // -----------------------------------------------------------------
   // User data record emitter
   // -----------------------------------------------------------------
   emit_state_e         emit_state;
   logic [3:0]          byte_idx;
   logic [TS_W-1:0]     rec_stamp;
   logic [REC_BITS-1:0] record;
   logic [7:0]          rec_byte;
   logic                fifo_ready;
   logic                emit_valid;
   logic                emit_fire;

   // Start code, identifier, then stamp with pad and two markers
   assign record = {USER_START_CODE,
                    STAMP_ID,
                    STAMP_PAD, rec_stamp[32:30],
                    STAMP_MARK, rec_stamp[29:15],
                    STAMP_MARK, rec_stamp[14:0]};
   assign rec_byte   = record[REC_BITS - 1 - 8 * byte_idx -: 8];
   assign emit_valid = (emit_state == EM_SEND);
   assign emit_fire  = emit_valid && fifo_ready;

   // Headers arriving mid-record are not queued; one record per frame
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         emit_state <= EM_IDLE;
         byte_idx   <= IDX_ZERO;
         rec_stamp  <= TS_ZERO;
      end
      else if (clk_en)
      begin
         unique case (emit_state)
            EM_IDLE:
               if (frame_in.header_done)
               begin
                  emit_state <= EM_SEND;
                  byte_idx   <= IDX_ZERO;
                  rec_stamp  <= stamp;
               end
            EM_SEND:
               if (emit_fire)
               begin
                  byte_idx <= byte_idx + IDX_ONE;
                  if (byte_idx == REC_LAST)
                     emit_state <= EM_IDLE;
               end
         endcase
      end
   end

   // Byte queue toward the stream; a stalled sink stalls the emitter
   byte_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .flush     (start_cmd),
      .in_data   (rec_byte),
      .in_valid  (emit_valid),
      .in_ready  (fifo_ready),
      .out_data  (stream_data),
      .out_valid (stream_valid),
      .out_ready (stream_ready)
   );
endmodule

`default_nettype wire

// [capture_timestamp_sync_checker.sv]
// Port-level checks for the capture stamp block.
// Assumes one clock domain; bound to the top module at the foot.
`timescale 1ns/1ns
`default_nettype none

module stamp_checker
   import capture_timestamp_sync_pkg::*;
(
   input wire logic            clk_sys,
   input wire logic            rst_b,
   input wire logic            clk_en,
   input wire logic            start_cmd,
   input wire frame_evt_s      frame_in,
   input wire telecine_s       telecine_in,
   input wire logic            valid_video_flag,
   input wire logic            capturing,
   input wire logic            frame_drop,
   input wire logic            seq_end,
   input wire logic            seq_start,
   input wire logic            seq_film,
   input wire logic [TS_W-1:0] stamp,
   input wire logic [7:0]      stream_data,
   input wire logic            stream_valid,
   input wire logic            stream_ready
);
   // ----------
   // Record byte position
   // ----------
   logic [3:0]        nbyte;
   wire  logic        acc = stream_valid && stream_ready && clk_en;
   wire  logic [47:0] hdr = {32'h000001b2, 16'h0207};

   // A flush inside a record would lose this alignment
   always_ff @(posedge clk_sys)
      if (!rst_b)
         nbyte <= 4'h0;
      else if (acc)
         nbyte <= (nbyte == 4'ha) ? 4'h0 : nbyte + 4'h1;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   AST_FLAG_NEEDS_CAPTURE: assert property (
      !$past(capturing) |-> !valid_video_flag)
      else $error("valid flag while not capturing");
   AST_LOST_STOPS: assert property (
      clk_en && frame_in.vsync_lost |=> !capturing && !valid_video_flag)
      else $error("capture kept after sync loss");
   AST_SYNC_RESUMES: assert property (
      clk_en && frame_in.vsync && !frame_in.vsync_lost |=> capturing)
      else $error("capture not resumed on sync");
   AST_STAMP_FORWARD: assert property (
      $changed(stamp) && $past(rst_b) && !$past(start_cmd)
      |-> stamp > $past(stamp))
      else $error("stamp stepped backward");
   AST_STAMP_CAUSE: assert property (
      $changed(stamp) |->
      $past(frame_in.first_pixel) || $past(start_cmd) || !$past(rst_b))
      else $error("stamp changed without first pixel");
   AST_BYTE_STANDS: assert property (
      stream_valid && !stream_ready && !start_cmd
      |=> stream_valid && $stable(stream_data))
      else $error("stream byte dropped while stalled");
   AST_HEAD_BYTES: assert property (
      acc && nbyte < 4'h6 |-> stream_data == hdr[47 - 8*nbyte -: 8])
      else $error("start code or identifier byte wrong");
   AST_PAD_BITS: assert property (
      acc && nbyte == 4'h6 |-> stream_data[7:3] == 5'h00)
      else $error("stamp pad bits not zero");
   AST_MARKERS: assert property (
      acc && (nbyte == 4'h7 || nbyte == 4'h9) |-> stream_data[7])
      else $error("stamp marker bit missing");
   AST_SEQ_PAIR: assert property (
      seq_start |-> seq_end ##1 !seq_start)
      else $error("sequence pulses not paired");
   AST_FILM_NTSC: assert property (
      $rose(seq_film) |->
      $past(telecine_in.detect_enable) && $past(telecine_in.ntsc))
      else $error("film mode without ntsc detection");
   AST_DROP_IN_FILM: assert property (
      frame_drop |-> seq_film)
      else $error("frame dropped outside film sequence");

   // Main scenarios reached
   cover property (acc && nbyte == 4'ha);
   cover property (seq_start && seq_film);
   cover property (frame_drop);
endmodule

bind capture_timestamp_sync stamp_checker chk
(
   .clk_sys, .rst_b, .clk_en, .start_cmd, .frame_in, .telecine_in,
   .valid_video_flag, .capturing, .frame_drop, .seq_end, .seq_start,
   .seq_film, .stamp, .stream_data, .stream_valid, .stream_ready
);

`default_nettype wire

// [capture_timestamp_sync_pkg.sv]
// Package for the capture time stamp block: stream record layout, time
// base constants, time base select codes and the carrier structs.
// Assumes a 10 MHz system clock and synchronous single-cycle strobes.
package capture_timestamp_sync_pkg;

   // -----------------------------------------------------------------
   // Clocks and time base
   // -----------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ = 10_000_000;
   localparam int unsigned SRC_CLK_HZ = 27_000_000;
   localparam int unsigned TICK_HZ    = 90_000;
   localparam int unsigned TICK_DIV   = SRC_CLK_HZ / TICK_HZ;
   localparam int unsigned DIV_W      = 9;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

   // -----------------------------------------------------------------
   // Capture time counter
   // -----------------------------------------------------------------
   localparam int unsigned TS_W = 33;
   localparam logic [TS_W-1:0] TS_ZERO = 33'h000000000;
   localparam logic [TS_W-1:0] TS_ONE  = 33'h000000001;

   // Time base select field, bits 5..6 of the video input control word
   localparam logic [1:0] TB_MAIN    = 2'h0;
   localparam logic [1:0] TB_DECODER = 2'h1;

   // -----------------------------------------------------------------
   // User data record
   // -----------------------------------------------------------------
   localparam logic [31:0] USER_START_CODE = 32'h000001b2;
   localparam logic [15:0] STAMP_ID        = 16'h0207;
   localparam logic [4:0]  STAMP_PAD       = 5'h00;
   localparam logic        STAMP_MARK      = 1'b1;
   localparam int unsigned REC_BYTES       = 11;
   localparam int unsigned REC_BITS        = REC_BYTES * 8;
   localparam logic [3:0]  REC_LAST        = 4'ha;
   localparam logic [3:0]  IDX_ZERO        = 4'h0;
   localparam logic [3:0]  IDX_ONE         = 4'h1;

   // -----------------------------------------------------------------
   // Telecine
   // -----------------------------------------------------------------
   localparam logic [2:0] FILM_DROP_SLOT = 3'h4;
   localparam logic [2:0] FILM_ZERO      = 3'h0;
   localparam logic [2:0] FILM_ONE       = 3'h1;

   // -----------------------------------------------------------------
   // Output FIFO
   // -----------------------------------------------------------------
   localparam int unsigned FIFO_W = 8;
   localparam int unsigned FIFO_D = 4;

   // Frame timing strobes from the video capture front end
   typedef struct packed {
      logic vsync;         // Vertical sync, one cycle
      logic vsync_lost;    // Sync fell out of step, one cycle
      logic first_pixel;   // First active pixel captured, one cycle
      logic header_done;   // Frame header written to stream, one cycle
      logic active;        // Active video level
   } frame_evt_s;

   // Telecine inputs
   typedef struct packed {
      logic detect_enable; // Telecine detection switched on
      logic ntsc;          // Input standard is NTSC
      logic film_found;    // Film cadence currently recognised
   } telecine_s;

endpackage

// [mux_sink.sv]
// Byte sink that stands in for the system multiplexer.
// Assumes the valid/ready byte handshake on clk_sys.
`timescale 1ns/1ns
`default_nettype none

module mux_sink
(
   input  wire logic       clk_sys,
   input  wire logic       hold,
   input  wire logic [7:0] stream_data,
   input  wire logic       stream_valid,
   output logic            stream_ready
);
   logic [7:0] got [$];
   logic [1:0] beat = 2'h0;
   logic       rdy  = 1'b0;

   assign stream_ready = rdy;

   // Slow sink: refuses one cycle in four, and every cycle while held
   always @(posedge clk_sys)
   begin
      if (stream_valid && stream_ready)
         got.push_back(stream_data);
      beat <= beat + 2'h1;
      rdy  <= !hold && (beat != 2'h3);
   end
endmodule

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the capture stamp block.
// Assumes the sink model and checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module tb_top
   import capture_timestamp_sync_pkg::*;
;
   typedef struct packed {
      logic [1:0]  sel;
      logic        m;
      logic        d;
      logic [11:0] k;
      logic [32:0] exp;
   } row_s;

   logic            clk_sys = 1'b0;
   logic            rst_b = 1'b0;
   logic            clk_en = 1'b1;
   logic            start_cmd = 1'b0;
   logic [1:0]      time_base_select = 2'h0;
   logic            decoder_pixel_clock = 1'b0;
   logic            main_clock_input = 1'b0;
   frame_evt_s      frame_in = '0;
   telecine_s       telecine_in = '0;
   logic            valid_video_flag, capturing, frame_drop;
   logic            seq_end, seq_start, seq_film;
   logic [TS_W-1:0] stamp;
   logic [7:0]      stream_data;
   logic            stream_valid, stream_ready;
   logic            hold = 1'b0;
   logic            act = 1'b0;
   logic [2:0]      tc = 3'h0;
   logic [32:0]     s;
   logic [87:0]     rec;
   int              fail_count = 0;
   int              tests_run = 0;

   // Offset k from start to first pixel; 12'h12c is 300 cycles
   row_s rows [6] = '{
      '{2'h0, 1'b1, 1'b0, 12'h12c, 33'h0},
      '{2'h1, 1'b0, 1'b1, 12'h12d, 33'h1},
      '{2'h3, 1'b1, 1'b0, 12'h12c, 33'h0},
      '{2'h1, 1'b1, 1'b0, 12'h259, 33'h0},
      '{2'h0, 1'b1, 1'b0, 12'h12d, 33'h1},
      '{2'h2, 1'b1, 1'b0, 12'h259, 33'h2}};

   capture_timestamp_sync DUT
   (
      .clk_sys, .rst_b, .clk_en, .start_cmd, .time_base_select,
      .decoder_pixel_clock, .main_clock_input, .frame_in, .telecine_in,
      .valid_video_flag, .capturing, .frame_drop, .seq_end, .seq_start,
      .seq_film, .stamp, .stream_data, .stream_valid, .stream_ready
   );

   mux_sink sink
   (
      .clk_sys, .hold, .stream_data, .stream_valid, .stream_ready
   );

   always #50 clk_sys = ~clk_sys;

   // ----------
   // Helpers
   // ----------
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // One-cycle strobes over the active level; telecine levels ride along
   task automatic evt(input logic [4:0] v);
      @(posedge clk_sys);
      frame_in <= frame_evt_s'(v | {4'h0, act});
      telecine_in <= telecine_s'(tc);
      @(posedge clk_sys);
      frame_in <= frame_evt_s'({4'h0, act});
      #1;
   endtask

   task automatic pulse_start(input row_s r);
      @(posedge clk_sys);
      start_cmd <= 1'b1;
      time_base_select <= r.sel;
      main_clock_input <= r.m;
      decoder_pixel_clock <= r.d;
      @(posedge clk_sys);
      start_cmd <= 1'b0;
   endtask

   task automatic do_reset;
      rst_b <= 1'b0;
      cyc(3);
      rst_b <= 1'b1;
      #1;
      chk_val(stamp, 33'h0);
      chk_bit(capturing | stream_valid | seq_film, 1'b0);
   endtask

   // Bounded wait; running out ends the run as a failure
   task automatic wait_bytes(input int n);
      int t;
      for (t = 0; t < 300 && sink.got.size() < n; t++)
         @(posedge clk_sys);
      if (sink.got.size() < n)
      begin
         fail_count++;
         give_verdict;
      end
   endtask

   // ----------
   // Main sequence
   // ----------
   initial
   begin
      do_reset;
      // Start at c0, vsync taken at c0+2, first pixel taken at c0+k
      foreach (rows[i])
      begin
         pulse_start(rows[i]);
         evt(5'h10);
         cyc(int'(rows[i].k) - 4);
         evt(5'h04);
         chk_val(stamp, rows[i].exp);
      end
      $display("test time base rows done");

      // Sink stalls: FIFO fills, the first byte must stand
      s = stamp;
      rec = {32'h000001b2, 16'h0207, 5'h00, s[32:30], 1'b1,
             s[29:15], 1'b1, s[14:0]};
      @(posedge clk_sys);
      hold <= 1'b1;
      evt(5'h02);
      cyc(20);
      #1;
      chk_bit(stream_valid, 1'b1);
      chk_val(33'(stream_data), 33'h0);
      @(posedge clk_sys);
      hold <= 1'b0;
      wait_bytes(11);
      for (int i = 0; i < 11; i++)
         chk_val(33'(sink.got[i]), 33'(rec[87 - 8*i -: 8]));
      $display("test record done");

      // Sync loss stops capture; stamp only moves on after resync
      act = 1'b1;
      evt(5'h00);
      chk_bit(valid_video_flag, 1'b1);
      evt(5'h08);
      chk_bit(capturing | valid_video_flag, 1'b0);
      evt(5'h04);
      chk_val(stamp, s);
      evt(5'h10);
      cyc(300);
      evt(5'h04);
      chk_bit(stamp > s, 1'b1);
      $display("test sync done");

      // Telecine: refused off NTSC, then film entry, drop slot, exit
      tc = 3'h5;
      evt(5'h10);
      chk_bit(seq_start | seq_film, 1'b0);
      tc = 3'h7; // Detection only with NTSC input
      evt(5'h10);
      chk_bit(seq_end & seq_start & seq_film, 1'b1);
      for (int i = 1; i <= 5; i++)
      begin
         evt(5'h10);
         chk_bit(frame_drop, i == 5);
      end
      s = stamp;
      evt(5'h04);
      chk_val(stamp, s);
      chk_bit(valid_video_flag, 1'b0);
      tc = 3'h6;
      evt(5'h10);
      chk_bit(seq_end & seq_start & !seq_film & !frame_drop, 1'b1);
      $display("test telecine done");

      // Clock enable low freezes state: a film vsync must not switch mode
      tc = 3'h7;
      @(posedge clk_sys);
      clk_en <= 1'b0;
      evt(5'h10);
      chk_bit(seq_start | seq_film, 1'b0);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      $display("test clock enable done");

      cyc(1);
      do_reset;
      $display("test second reset done");
      give_verdict;
   end
endmodule

`default_nettype wire
